// file: hdl/lsc_consts.vh
`ifndef LSC_CONSTS_VH
`define LSC_CONSTS_VH

// Fixed slave address byte, write direction included.
`define LSC_SLAVE_ADDR 8'h74

// Control byte layout.
`define LSC_SBV_MSB 5
`define LSC_SBV_LSB 0
`define LSC_MODE_BIT 6
`define LSC_BANK_BIT 7

// Reset values.
`define LSC_CTRL_RESET 8'h00
`define LSC_SEG_RESET 8'h00

// Vector steps per stored byte.
`define LSC_STEP_DIRECT 6'h02
`define LSC_STEP_DUPLEX 6'h01

// Bits per byte on the serial link, counted from zero.
`define LSC_LAST_BIT 4'h7

`endif

// file: hdl/lsc_load_control.v
`timescale 1ns/100ps
// Behaviour
// - Control register plus eight segment byte registers.
// - Even registers bank A, odd bank B.
// - Every addressed device stores second byte as control.
// - Low control bits form the segment byte vector.
// - Upper vector bits vs subaddress gate storing.
// - Lowest three vector bits pick the register.
// - Mode bit zero selects direct drive.
// - Bank bit picks displayed bank in direct.
// - Vector advances after each segment byte.
// - Increment carries into subaddress bits.
// - Direct drive advances vector by two.
// - Either bank loadable whatever is displayed.
// - Direct: four bytes feed 32 segments.
// - Low subaddress reads zero when oscillator used.
// - Direct: high pin is subaddress, open reads zero.
// - Duplex: high pin is backplane, two-bit match.
// - Oscillator tied to rail means cascade mode.
// - Only address byte 0111 0100 accepted.
// - Duplex: step one, bank bit ignored.
// - Reset clears registers, blanks outputs, idles bus.
// - Duplex: even to first, odd second backplane.
`include "lsc_consts.vh"

module lsc_load_control (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Serial bus pins
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe,
    // Subaddress and oscillator pins
    input wire subaddr_low_or_osc_pin,
    input wire osc_rc_fitted,
    input wire subaddr_bit_mid,
    input wire subaddr_high_or_second_backplane_pin,
    // Display data towards the waveform generator
    output reg [31:0] segment_outputs,
    output reg [31:0] segment_second_plane,
    output reg duplex_mode,
    output reg cascade_mode,
    output reg second_backplane_drive,
    // Readback of the control byte
    output reg [7:0] load_and_display_control
);

    // Receiver states; a foreign address parks the receiver in idle until a new start.
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_CTRL = 3'h2;
    localparam ST_DATA = 3'h3;

    // Pin synchronisers; stage one feeds stage two only.
    reg scl_s1_reg;
    reg scl_s2_reg;
    reg scl_d_reg;
    reg sda_s1_reg;
    reg sda_s2_reg;
    reg sda_d_reg;
    reg a0_s1_reg;
    reg a0_s2_reg;
    reg rc_s1_reg;
    reg rc_s2_reg;
    reg a1_s1_reg;
    reg a1_s2_reg;
    reg a2_s1_reg;
    reg a2_s2_reg;

    reg [2:0] state_reg;
    reg [3:0] bit_cnt_reg;
    reg [7:0] shift_reg;
    reg ack_pending_reg;
    reg in_ack_reg;
    reg [7:0] seg_mem [0:7];

    wire scl_rise;
    wire scl_fall;
    wire start_cond;
    wire stop_cond;
    wire [7:0] rx_byte;
    wire [5:0] segment_byte_vector;
    wire [2:0] own_subaddr;
    wire subaddr_hit;
    wire [5:0] sbv_step;

    integer k;

    // Selects which register of a pair is shown on a plane.
    function [7:0] pick_byte;
        input [7:0] even_byte;
        input [7:0] odd_byte;
        input use_odd;
        begin
            pick_byte = use_odd ? odd_byte : even_byte;
        end
    endfunction

    assign sda_out = 1'b0;
    assign scl_rise = scl_s2_reg & ~scl_d_reg;
    assign scl_fall = ~scl_s2_reg & scl_d_reg;
    assign start_cond = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
    assign stop_cond = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;
    assign rx_byte = {shift_reg[6:0], sda_s2_reg};
    assign segment_byte_vector = load_and_display_control[`LSC_SBV_MSB:`LSC_SBV_LSB];

    // An RC network on the shared pin reads as a low address bit.
    assign own_subaddr = {a2_s2_reg, a1_s2_reg, a0_s2_reg & ~rc_s2_reg};

    // Duplex drops the high bit because that pin carries a backplane.
    assign subaddr_hit = duplex_mode ? (segment_byte_vector[4:3] == own_subaddr[1:0])
                                     : (segment_byte_vector[5:3] == own_subaddr);

    assign sbv_step = duplex_mode ? `LSC_STEP_DUPLEX : `LSC_STEP_DIRECT;

    // Bus lines reset to their idle high level, so release of reset shows no false edge.
    // The delay stage after the synchroniser is only there to find edges.
    always @(posedge clk) begin
        if (srst) begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_d_reg <= 1'b1;
        end else begin
            scl_s1_reg <= scl_in;
            scl_s2_reg <= scl_s1_reg;
            scl_d_reg <= scl_s2_reg;
        end
    end

    // The data line goes through the same depth as the clock line, so that start and
    // stop are judged on levels of one and the same instant.
    always @(posedge clk) begin
        if (srst) begin
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            sda_s1_reg <= sda_in;
            sda_s2_reg <= sda_s1_reg;
            sda_d_reg <= sda_s2_reg;
        end
    end

    // Strap pins are static in use, so two plain stages are enough for them.
    always @(posedge clk) begin
        if (srst) begin
            a0_s1_reg <= 1'b0;
            a0_s2_reg <= 1'b0;
        end else begin
            a0_s1_reg <= subaddr_low_or_osc_pin;
            a0_s2_reg <= a0_s1_reg;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            rc_s1_reg <= 1'b0;
            rc_s2_reg <= 1'b0;
        end else begin
            rc_s1_reg <= osc_rc_fitted;
            rc_s2_reg <= rc_s1_reg;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            a1_s1_reg <= 1'b0;
            a1_s2_reg <= 1'b0;
        end else begin
            a1_s1_reg <= subaddr_bit_mid;
            a1_s2_reg <= a1_s1_reg;
        end
    end

    // An open high pin reads low, matching the pull-down that sits on it.
    always @(posedge clk) begin
        if (srst) begin
            a2_s1_reg <= 1'b0;
            a2_s2_reg <= 1'b0;
        end else begin
            a2_s1_reg <= subaddr_high_or_second_backplane_pin;
            a2_s2_reg <= a2_s1_reg;
        end
    end

    // Serial receiver, control byte and segment store.
    // Each phase of the serial clock must last at least four system clocks;
    // shorter phases would slip past the synchroniser and lose bits.
    always @(posedge clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ack_pending_reg <= 1'b0;
            in_ack_reg <= 1'b0;
            sda_oe <= 1'b0;
            load_and_display_control <= `LSC_CTRL_RESET;
            for (k = 0; k < 8; k = k + 1) begin
                seg_mem[k] <= `LSC_SEG_RESET;
            end
        end else if (start_cond) begin
            // A repeated start also lands here and restarts addressing.
            state_reg <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
            ack_pending_reg <= 1'b0;
            in_ack_reg <= 1'b0;
            sda_oe <= 1'b0;
        end else if (stop_cond) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            ack_pending_reg <= 1'b0;
            in_ack_reg <= 1'b0;
            sda_oe <= 1'b0;
        end else if (state_reg != ST_IDLE) begin
            if (scl_fall && ack_pending_reg) begin
                ack_pending_reg <= 1'b0;
                in_ack_reg <= 1'b1;
                sda_oe <= 1'b1;
            end else if (scl_fall && in_ack_reg) begin
                in_ack_reg <= 1'b0;
                sda_oe <= 1'b0;
                bit_cnt_reg <= 4'h0;
            end else if (scl_rise && !in_ack_reg && !ack_pending_reg) begin
                shift_reg <= rx_byte;
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                if (bit_cnt_reg == `LSC_LAST_BIT) begin
                    ack_pending_reg <= 1'b1;
                    case (state_reg)
                        ST_ADDR: begin
                            if (rx_byte == `LSC_SLAVE_ADDR) begin
                                state_reg <= ST_CTRL;
                            end else begin
                                // Foreign address: stay silent until the next start.
                                state_reg <= ST_IDLE;
                                ack_pending_reg <= 1'b0;
                            end
                        end
                        ST_CTRL: begin
                            load_and_display_control <= rx_byte;
                            state_reg <= ST_DATA;
                        end
                        ST_DATA: begin
                            // Non-matching devices still ack and advance the vector.
                            if (subaddr_hit) begin
                                seg_mem[segment_byte_vector[2:0]] <= rx_byte;
                            end
                            load_and_display_control[`LSC_SBV_MSB:`LSC_SBV_LSB] <=
                                segment_byte_vector + sbv_step;
                        end
                        default: begin
                            state_reg <= ST_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    // Display planes, mode and backplane pin role.
    // The planes follow the registers one clock later, which keeps them glitch free.
    always @(posedge clk) begin
        if (srst) begin
            segment_outputs <= 32'h0000_0000;
            segment_second_plane <= 32'h0000_0000;
            duplex_mode <= 1'b0;
            cascade_mode <= 1'b0;
            second_backplane_drive <= 1'b0;
        end else begin
            duplex_mode <= load_and_display_control[`LSC_MODE_BIT];
            cascade_mode <= ~rc_s2_reg;
            second_backplane_drive <= load_and_display_control[`LSC_MODE_BIT];
            for (k = 0; k < 4; k = k + 1) begin
                if (load_and_display_control[`LSC_MODE_BIT]) begin
                    segment_outputs[8*k +: 8] <= seg_mem[2*k];
                    segment_second_plane[8*k +: 8] <= seg_mem[2*k+1];
                end else begin
                    segment_outputs[8*k +: 8] <= pick_byte(seg_mem[2*k], seg_mem[2*k+1],
                        load_and_display_control[`LSC_BANK_BIT]);
                    segment_second_plane[8*k +: 8] <= 8'h00;
                end
            end
        end
    end

endmodule // lsc_load_control

// file: tb/lsc_load_control_chk.sv
`timescale 1ns/100ps
module lsc_load_control_chk (
    // Clock, reset, serial pins and oscillator strap
    input logic clk,
    input logic srst,
    input logic scl_in,
    input logic sda_in,
    input logic sda_out,
    input logic sda_oe,
    input logic osc_rc_fitted,
    // Display and control
    input logic [31:0] segment_outputs,
    input logic [31:0] segment_second_plane,
    input logic duplex_mode,
    input logic cascade_mode,
    input logic second_backplane_drive,
    input logic [7:0] load_and_display_control
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    chk_reset_clears: assert property (disable iff (1'b0) srst |=> load_and_display_control == 0
        && segment_outputs == 0 && !sda_oe) else $error("reset left state");
    chk_mode_bit: assert property ($stable(load_and_display_control)[*2]
        |-> duplex_mode == load_and_display_control[6]) else $error("mode bit");
    chk_bp_follows: assert property ($stable(duplex_mode)[*2]
        |-> second_backplane_drive == duplex_mode) else $error("backplane pin");
    chk_plane_blank: assert property ((!duplex_mode)[*3]
        |-> segment_second_plane == 0) else $error("second plane in direct");
    chk_ack_width: assert property ($rose(sda_oe) |-> sda_oe[*6]) else $error("ack short");
    chk_cascade_strap: assert property ($stable(osc_rc_fitted)[*5]
        |-> cascade_mode == !osc_rc_fitted) else $error("cascade");
    // Eight quiet cycles outlast the synchroniser and the store pipeline.
    chk_idle_hold: assert property (($stable(scl_in) && $stable(sda_in))[*8]
        |-> $stable(load_and_display_control) && $stable(segment_outputs))
        else $error("change on idle bus");
    chk_sda_low: assert property (sda_out == 1'b0) else $error("sda drives high");
endmodule // lsc_load_control_chk

bind lsc_load_control lsc_load_control_chk u_chk (.clk, .srst, .scl_in, .sda_in, .sda_out,
    .sda_oe, .osc_rc_fitted, .segment_outputs, .segment_second_plane, .duplex_mode,
    .cascade_mode, .second_backplane_drive, .load_and_display_control);

// file: tb/lsc_bus_master.sv
`timescale 1ns/100ps
module lsc_bus_master (
    // Clock
    input logic clk,
    // Bus lines
    input logic sda,
    output logic scl,
    output logic sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic start_cond();
        tick(4);
        sda_drv <= 1'b0;
        tick(4);
        scl <= 1'b0;
    endtask
    // Data moves two clocks after the fall so it never races the clock edge.
    task automatic clock_bit(input logic b, output logic seen);
        tick(2);
        sda_drv <= b;
        tick(2);
        scl <= 1'b1;
        tick(2);
        seen = sda;
        tick(2);
        scl <= 1'b0;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
        clock_bit(1'b1, s);
        ack = !s;
    endtask
    task automatic stop_cond();
        tick(2);
        sda_drv <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_drv <= 1'b1;
    endtask
endmodule // lsc_bus_master

// file: tb/lcd_segment_load_control_bench.sv
`timescale 1ns/100ps
module lcd_segment_load_control_bench;
    logic clk, srst, scl, sda_drv, sda_oe, sda_out, lo_pin, rc, mid_pin, hi_pin;
    logic dup, casc, bp2;
    logic [31:0] seg_out, seg_two, r;
    logic [7:0] ctrl, exp_ctrl;
    logic [7:0] mem [8];
    int error_cnt, n_checks, seed;
    // Open-drain wire with pull-up: low when either side pulls.
    wire sda = sda_drv & ~sda_oe;
    lsc_load_control DUT (.clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .subaddr_low_or_osc_pin(lo_pin),
        .osc_rc_fitted(rc), .subaddr_bit_mid(mid_pin),
        .subaddr_high_or_second_backplane_pin(hi_pin), .segment_outputs(seg_out),
        .segment_second_plane(seg_two), .duplex_mode(dup), .cascade_mode(casc),
        .second_backplane_drive(bp2), .load_and_display_control(ctrl));
    lsc_bus_master master (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic transfer(input logic [7:0] addr, input logic [7:0] cb, input int n);
        logic a;
        logic [7:0] d;
        logic [5:0] v;
        logic [2:0] sub;
        master.start_cond();
        master.send_byte(addr, a);
        check(a, addr == 8'h74);
        if (addr == 8'h74) begin
            master.send_byte(cb, a);
            check(a, 1'b1);
            exp_ctrl = cb;
            repeat (n) begin
                d = $random(seed);
                master.send_byte(d, a);
                check(a, 1'b1);
                v = exp_ctrl[5:0];
                sub = {hi_pin, mid_pin, lo_pin & ~rc};
                if (exp_ctrl[6] ? v[4:3] == sub[1:0] : v[5:3] == sub) mem[v[2:0]] = d;
                exp_ctrl[5:0] = v + (exp_ctrl[6] ? 6'h01 : 6'h02);
            end
        end
        master.stop_cond();
        master.tick(4);
        check(ctrl, exp_ctrl);
        for (int k = 0; k < 4; k++) begin
            check(seg_out[8*k+:8], exp_ctrl[7:6] == 2'b10 ? mem[2*k+1] : mem[2*k]);
            check(seg_two[8*k+:8], exp_ctrl[6] ? mem[2*k+1] : 8'h00);
        end
        check(dup, exp_ctrl[6]);
        check(bp2, exp_ctrl[6]);
        check(casc, !rc);
    endtask
    initial begin
        seed = 35;
        srst = 1'b1;
        {hi_pin, mid_pin, lo_pin, rc} = 4'h0;
        error_cnt = 0;
        n_checks = 0;
        exp_ctrl = 8'h00;
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        check({ctrl, seg_out[23:0]}, 32'h0000_0000);
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            {hi_pin, mid_pin, lo_pin, rc} <= r[3:0];
            // Odd passes aim the vector at this device so loads really land.
            transfer(i % 7 == 3 ? 8'h75 : 8'h74,
                i % 2 ? {r[15:14], r[3:2], r[1] & ~r[0], r[10:8]} : r[23:16], i % 11);
        end
        report_and_stop();
    end
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
endmodule // lcd_segment_load_control_bench
